// [core/csm_byte_lane.sv]
// Byte lane placement for one data access in either byte order.
`timescale 1ns/1ns
module csm_byte_lane
	import csm_pkg::*;
(
	input wire logic [1:0] offset_in,
	input wire logic [1:0] size_in,
	input wire logic big_endian_in,
	input wire logic [31:0] wdata_in,
	output logic [3:0] lane_en_out,
	output logic [31:0] lane_data_out,
	output logic [1:0] word_span_out
);

	// Shift a value left by a whole number of bytes.
	function automatic logic [63:0] rot_bytes(input logic [63:0] v,
		input logic [2:0] n);
		logic [6:0] sh;
		sh = {n, 3'h0} + 7'h00;
		rot_bytes = v << sh;
	endfunction

	logic [31:0] ordered;
	logic [63:0] shifted;
	logic [7:0] mask8;

	// Order bytes within the item; big-endian reverses them so the top
	// byte meets the lowest address. Lanes then shift by the offset.
	always_comb
	begin
		ordered = wdata_in;
		mask8 = 8'h00;
		if (size_in == CSM_SIZE_WORD)
		begin
			mask8 = 8'h0F;
			if (big_endian_in)
				ordered = {wdata_in[7:0], wdata_in[15:8],
					wdata_in[23:16], wdata_in[31:24]};
		end
		else if (size_in == CSM_SIZE_HALF)
		begin
			mask8 = 8'h03;
			if (big_endian_in)
				ordered = {16'h0000, wdata_in[7:0], wdata_in[15:8]};
			else
				ordered = {16'h0000, wdata_in[15:0]};
		end
		else
		begin
			mask8 = 8'h01;
			ordered = {24'h00_0000, wdata_in[7:0]};
		end
		shifted = rot_bytes({32'h0000_0000, ordered}, {1'b0, offset_in});
		mask8 = mask8 << offset_in;
		lane_en_out = mask8[3:0];
		lane_data_out = shifted[31:0];
		word_span_out = (mask8[7:4] != 4'h0) ? 2'h2 : 2'h1;
	end

endmodule

// [core/csm_core_ctrl.sv]
// Core state, mode tracking and data byte order placement.
`timescale 1ns/1ns
module csm_core_ctrl
	import csm_pkg::*;
#(
	parameter int PHYS_REGS = 23
)
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire csm_event_req_t event_in,
	input wire logic [31:0] fetch_addr_in,
	input wire logic fetch_is_32_in,
	input wire logic [3:0] reg_index_in,
	input wire csm_access_t access_in,
	input wire logic region_shared_in,
	input wire logic region_cacheable_in,
	input wire logic protected_req_in,
	output csm_mode_t mode_out,
	output csm_iset_t iset_out,
	output logic privileged_out,
	output logic protected_grant_out,
	output logic fetch_fault_out,
	output logic [4:0] phys_reg_out,
	output csm_lanes_t lanes_out,
	output logic coherency_hw_out
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	// The physical index is five bits wide, so more than 32 cannot be named.
	if (PHYS_REGS < CSM_GPR_COUNT + CSM_FIQ_BANK_LAST - CSM_FIQ_BANK_FIRST + 1
		|| PHYS_REGS > 32)
	begin : g_bad_regs
		$error("PHYS_REGS outside what the fast bank and index can serve");
	end

	// ****************************************
	// Helper functions
	// ****************************************

	// True for every mode apart from user.
	function automatic logic is_privileged(input csm_mode_t m);
		is_privileged = (m != CSM_MODE_USER);
	endfunction

	// True when the encoding is one of the seven defined modes.
	function automatic logic is_valid_mode(input logic [4:0] m);
		case (m)
			CSM_MODE_USER, CSM_MODE_FAST_IRQ, CSM_MODE_IRQ,
			CSM_MODE_SUPERVISOR, CSM_MODE_ABORT, CSM_MODE_UNDEFINED,
			CSM_MODE_SYSTEM: is_valid_mode = 1'b1;
			default: is_valid_mode = 1'b0;
		endcase
	endfunction

	// ****************************************
	// Status register
	// ****************************************
	csm_mode_t mode_reg;
	csm_mode_t mode_next;
	csm_iset_t iset_reg;
	csm_iset_t iset_next;
	logic is_exchange;

	// Work out the next mode and state from the single event this cycle.
	// Only the listed events touch the status; anything else holds it.
	always_comb
	begin
		mode_next = mode_reg;
		iset_next = iset_reg;
		is_exchange = 1'b0;
		if (event_in.valid)
		begin
			case (event_in.kind)
				CSM_EV_BRANCH_EXCHANGE, CSM_EV_BRANCH_LINK_EXCHANGE,
				CSM_EV_BRANCH_EXCHANGE_BYTECODE, CSM_EV_LOAD_PC:
				begin
					is_exchange = 1'b1;
				end
				CSM_EV_DATA_PROC_PC:
				begin
					is_exchange = !event_in.sets_flags;
				end
				CSM_EV_FAST_IRQ:
				begin
					mode_next = CSM_MODE_FAST_IRQ;
					iset_next = csm_iset_t'(event_in.handler_compact);
				end
				CSM_EV_IRQ:
				begin
					mode_next = CSM_MODE_IRQ;
					iset_next = csm_iset_t'(event_in.handler_compact);
				end
				CSM_EV_SUPERVISOR_CALL:
				begin
					mode_next = CSM_MODE_SUPERVISOR;
					iset_next = csm_iset_t'(event_in.handler_compact);
				end
				CSM_EV_DATA_ABORT, CSM_EV_PREFETCH_ABORT:
				begin
					mode_next = CSM_MODE_ABORT;
					iset_next = csm_iset_t'(event_in.handler_compact);
				end
				CSM_EV_UNDEFINED:
				begin
					mode_next = CSM_MODE_UNDEFINED;
					iset_next = csm_iset_t'(event_in.handler_compact);
				end
				CSM_EV_MODE_WRITE:
				begin
					// User mode cannot raise itself; bad codes are ignored.
					if (is_privileged(mode_reg) &&
						is_valid_mode(event_in.new_mode))
						mode_next = event_in.new_mode;
				end
				default:
				begin
					mode_next = mode_reg;
				end
			endcase
			// An exchange alters only the state bit, never the mode.
			if (is_exchange)
				iset_next = csm_iset_t'(event_in.target_lsb);
		end
	end

	// Status register update.
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			mode_reg <= csm_mode_t'(CSM_RESET_MODE);
			iset_reg <= csm_iset_t'(CSM_RESET_ISET);
		end
		else
		begin
			mode_reg <= mode_next;
			iset_reg <= iset_next;
		end
	end

	assign mode_out = mode_reg;
	assign iset_out = iset_reg;
	assign privileged_out = is_privileged(mode_reg);
	assign protected_grant_out = protected_req_in &&
		is_privileged(mode_reg);

	// ****************************************
	// Fetch alignment check
	// ****************************************

	// Wide state demands word alignment and rejects 16-bit fetches;
	// compact state needs halfword alignment only.
	always_comb
	begin
		if (iset_reg == CSM_ISET_WIDE)
			fetch_fault_out = ((fetch_addr_in[1:0] &
				CSM_WIDE_ALIGN_MASK) != 2'h0) || !fetch_is_32_in;
		else
			fetch_fault_out = (fetch_addr_in[0] &
				CSM_COMPACT_ALIGN_MASK[0]) != 1'b0;
	end

	// ****************************************
	// Register bank selection
	// ****************************************
	logic in_fiq_bank;

	// Fast mode swaps ..for its own copies placed after the shared
	// sixteen. The other banked copies live in a separate register block.
	always_comb
	begin
		in_fiq_bank = (mode_reg == CSM_MODE_FAST_IRQ) &&
			(reg_index_in >= 4'(CSM_FIQ_BANK_FIRST)) &&
			(reg_index_in <= 4'(CSM_FIQ_BANK_LAST));
		if (in_fiq_bank)
			phys_reg_out = 5'(CSM_GPR_COUNT) +
				5'(reg_index_in - 4'(CSM_FIQ_BANK_FIRST));
		else
			phys_reg_out = {1'b0, reg_index_in};
	end

	// ****************************************
	// Data byte placement
	// ****************************************
	logic [3:0] lane_en;
	logic [31:0] lane_data;
	logic [1:0] word_span;

	// Each access picks its own byte order, so mixed order costs nothing.
	csm_byte_lane u_lane
	(
		.offset_in(access_in.addr[1:0]),
		.size_in(access_in.size),
		.big_endian_in(access_in.big_endian),
		.wdata_in(access_in.wdata),
		.lane_en_out(lane_en),
		.lane_data_out(lane_data),
		.word_span_out(word_span)
	);

	// Register the placed lanes with the cache allocation decision.
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			lanes_out <= '0;
		end
		else
		begin
			lanes_out.valid <= access_in.valid;
			lanes_out.lane_en <= lane_en;
			lanes_out.lane_data <= lane_data;
			lanes_out.word_span <= word_span;
			// Shared data stays out of level one so other masters see it.
			lanes_out.allocate_l1 <= access_in.valid &&
				region_cacheable_in && !region_shared_in;
		end
	end

	// No snooping exists between twin cores; software must maintain it.
	assign coherency_hw_out = 1'b0;

endmodule

// [core/csm_pkg.sv]
// Package with types and constants for the core state, mode and byte order block.
package csm_pkg;

	// ****************************************
	// Mode and state encodings
	// ****************************************
	typedef enum logic [4:0]
	{
		CSM_MODE_USER = 5'h10,
		CSM_MODE_FAST_IRQ = 5'h11,
		CSM_MODE_IRQ = 5'h12,
		CSM_MODE_SUPERVISOR = 5'h13,
		CSM_MODE_ABORT = 5'h17,
		CSM_MODE_UNDEFINED = 5'h1B,
		CSM_MODE_SYSTEM = 5'h1F
	} csm_mode_t;

	typedef enum logic [0:0]
	{
		CSM_ISET_WIDE = 1'b0,
		CSM_ISET_COMPACT = 1'b1
	} csm_iset_t;

	// ****************************************
	// Events
	// ****************************************
	typedef enum logic [3:0]
	{
		CSM_EV_NONE = 4'h0,
		CSM_EV_BRANCH_EXCHANGE = 4'h1,
		CSM_EV_BRANCH_LINK_EXCHANGE = 4'h2,
		CSM_EV_BRANCH_EXCHANGE_BYTECODE = 4'h3,
		CSM_EV_LOAD_PC = 4'h4,
		CSM_EV_DATA_PROC_PC = 4'h5,
		CSM_EV_FAST_IRQ = 4'h6,
		CSM_EV_IRQ = 4'h7,
		CSM_EV_SUPERVISOR_CALL = 4'h8,
		CSM_EV_DATA_ABORT = 4'h9,
		CSM_EV_PREFETCH_ABORT = 4'hA,
		CSM_EV_UNDEFINED = 4'hB,
		CSM_EV_MODE_WRITE = 4'hC
	} csm_event_t;

	// Instruction-flow event from the decode stage.
	typedef struct packed
	{
		logic valid;
		csm_event_t kind;
		logic target_lsb;
		logic sets_flags;
		logic handler_compact;
		csm_mode_t new_mode;
	} csm_event_req_t;

	// Data access request and the byte lanes it produces.
	typedef struct packed
	{
		logic valid;
		logic [31:0] addr;
		logic [1:0] size;
		logic big_endian;
		logic [31:0] wdata;
	} csm_access_t;

	typedef struct packed
	{
		logic valid;
		logic [3:0] lane_en;
		logic [31:0] lane_data;
		logic [1:0] word_span;
		logic allocate_l1;
	} csm_lanes_t;

	// ****************************************
	// Constants
	// ****************************************
	localparam logic [1:0] CSM_SIZE_BYTE = 2'h0;
	localparam logic [1:0] CSM_SIZE_HALF = 2'h1;
	localparam logic [1:0] CSM_SIZE_WORD = 2'h2;
	localparam logic [1:0] CSM_WIDE_ALIGN_MASK = 2'h3;
	localparam logic [1:0] CSM_COMPACT_ALIGN_MASK = 2'h1;
	localparam int CSM_GPR_COUNT = 16;
	localparam int CSM_FIQ_BANK_FIRST = 8;
	localparam int CSM_FIQ_BANK_LAST = 14;
	localparam logic [4:0] CSM_RESET_MODE = 5'h13;
	localparam logic CSM_RESET_ISET = 1'b0;

endpackage

// [verification/csm_core_ctrl_props.sv]
// Assertion checker for the core state, mode and byte order block.
`timescale 1ns/1ns
module csm_core_ctrl_props
	import csm_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire csm_event_req_t event_in,
	input wire logic [31:0] fetch_addr_in,
	input wire logic fetch_is_32_in,
	input wire logic [3:0] reg_index_in,
	input wire csm_access_t access_in,
	input wire logic region_shared_in,
	input wire logic region_cacheable_in,
	input wire logic protected_req_in,
	input wire csm_mode_t mode_out,
	input wire csm_iset_t iset_out,
	input wire logic privileged_out,
	input wire logic protected_grant_out,
	input wire logic fetch_fault_out,
	input wire logic [4:0] phys_reg_out,
	input wire csm_lanes_t lanes_out,
	input wire logic coherency_hw_out
);
	// ****
	// Checks
	// ****
	// One clock domain, so the clock and reset are given once here.
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// An accepted event of the given kind on this edge.
	sequence ev_s(csm_event_t k);
		event_in.valid && event_in.kind == k;
	endsequence

	fiq_entry_a: assert property (ev_s(CSM_EV_FAST_IRQ)
		|=> mode_out == CSM_MODE_FAST_IRQ) else $error("No fast mode.");
	svc_entry_a: assert property (ev_s(CSM_EV_SUPERVISOR_CALL)
		|=> mode_out == CSM_MODE_SUPERVISOR) else $error("No svc mode.");
	abort_entry_a: assert property (ev_s(CSM_EV_DATA_ABORT)
		|=> mode_out == CSM_MODE_ABORT) else $error("No abort mode.");
	undef_entry_a: assert property (ev_s(CSM_EV_UNDEFINED)
		|=> mode_out == CSM_MODE_UNDEFINED) else $error("No undef mode.");
	handler_state_a: assert property (ev_s(CSM_EV_IRQ)
		|=> iset_out == $past(event_in.handler_compact))
		else $error("Handler state wrong.");
	exchange_keep_a: assert property (ev_s(CSM_EV_BRANCH_EXCHANGE)
		|=> $stable(mode_out) && iset_out == $past(event_in.target_lsb))
		else $error("Exchange changed mode or missed state.");
	idle_hold_a: assert property (!event_in.valid
		|=> $stable(mode_out) && $stable(iset_out)) else $error("Idle change.");
	grant_priv_a: assert property (protected_grant_out ==
		(protected_req_in && mode_out != CSM_MODE_USER))
		else $error("Grant does not follow privilege.");
	fiq_bank_a: assert property (mode_out == CSM_MODE_FAST_IRQ
		&& reg_index_in inside {[8:14]} |-> phys_reg_out == reg_index_in + 8)
		else $error("Fast bank index wrong.");
	wide_align_a: assert property (iset_out == CSM_ISET_WIDE
		&& fetch_addr_in[1:0] != 2'h0 |-> fetch_fault_out)
		else $error("Unaligned wide fetch not refused.");
	compact_align_a: assert property (iset_out == CSM_ISET_COMPACT
		|-> fetch_fault_out == fetch_addr_in[0]) else $error("Compact fault.");
	shared_noalloc_a: assert property (access_in.valid
		&& region_shared_in |=> !lanes_out.allocate_l1)
		else $error("Shared data allocated.");
endmodule

bind csm_core_ctrl csm_core_ctrl_props csm_core_ctrl_props_inst
(
	.sys_clk_in(sys_clk_in),
	.rst_in(rst_in),
	.event_in(event_in),
	.fetch_addr_in(fetch_addr_in),
	.fetch_is_32_in(fetch_is_32_in),
	.reg_index_in(reg_index_in),
	.access_in(access_in),
	.region_shared_in(region_shared_in),
	.region_cacheable_in(region_cacheable_in),
	.protected_req_in(protected_req_in),
	.mode_out(mode_out),
	.iset_out(iset_out),
	.privileged_out(privileged_out),
	.protected_grant_out(protected_grant_out),
	.fetch_fault_out(fetch_fault_out),
	.phys_reg_out(phys_reg_out),
	.lanes_out(lanes_out),
	.coherency_hw_out(coherency_hw_out)
);

// [verification/csm_core_ctrl_tb.sv]
// Self-checking testbench for the core state, mode and byte order block.
`timescale 1ns/1ns
module csm_core_ctrl_tb
	import csm_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	csm_event_req_t event_in = '0;
	logic [31:0] fetch_addr_in = '0;
	logic fetch_is_32_in = 1'b0;
	logic [3:0] reg_index_in = '0;
	csm_access_t access_in = '0;
	logic region_shared_in = 1'b0;
	logic region_cacheable_in = 1'b0;
	logic protected_req_in = 1'b0;
	csm_mode_t mode_out;
	csm_iset_t iset_out;
	logic privileged_out;
	logic protected_grant_out;
	logic fetch_fault_out;
	logic coherency_hw_out;
	logic [4:0] phys_reg_out;
	csm_lanes_t lanes_out;
	int n_mismatch = 0;
	int samples_checked = 0;
	csm_mode_t m_mode;
	logic m_iset;

	// ****
	// Harness
	// ****
	// The design runs at its full bank size.
	csm_core_ctrl #(.PHYS_REGS(23)) csm_core_ctrl_inst
	(
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.event_in(event_in),
		.fetch_addr_in(fetch_addr_in),
		.fetch_is_32_in(fetch_is_32_in),
		.reg_index_in(reg_index_in),
		.access_in(access_in),
		.region_shared_in(region_shared_in),
		.region_cacheable_in(region_cacheable_in),
		.protected_req_in(protected_req_in),
		.mode_out(mode_out),
		.iset_out(iset_out),
		.privileged_out(privileged_out),
		.protected_grant_out(protected_grant_out),
		.fetch_fault_out(fetch_fault_out),
		.phys_reg_out(phys_reg_out),
		.lanes_out(lanes_out),
		.coherency_hw_out(coherency_hw_out)
	);

	// Free-running 10 MHz clock.
	always #50 sys_clk_in = ~sys_clk_in;

	// Compares one value with the model's expectation.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic stop_test;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Sends one event, steps the model and checks the status, grant, fetch fault and register index outputs.
	task automatic ev(input csm_event_t k, input logic lsb, input logic fl,
		input logic hc, input csm_mode_t nm);
		logic ff;
		@(posedge sys_clk_in);
		#1;
		event_in = {1'b1, k, lsb, fl, hc, nm};
		@(posedge sys_clk_in);
		#1;
		event_in.valid = 1'b0;
		fetch_addr_in = $urandom;
		fetch_is_32_in = 1'($urandom);
		reg_index_in = 4'($urandom);
		protected_req_in = 1'($urandom);
		#1;
		if (k >= CSM_EV_FAST_IRQ && k <= CSM_EV_UNDEFINED)
			m_iset = hc;
		else if (k == CSM_EV_MODE_WRITE && m_mode != CSM_MODE_USER &&
			nm inside {CSM_MODE_USER, CSM_MODE_FAST_IRQ, CSM_MODE_IRQ,
			CSM_MODE_SUPERVISOR, CSM_MODE_ABORT, CSM_MODE_UNDEFINED,
			CSM_MODE_SYSTEM})
			m_mode = nm;
		else if (k != CSM_EV_MODE_WRITE && !(k == CSM_EV_DATA_PROC_PC && fl))
			m_iset = lsb;
		case (k)
			CSM_EV_FAST_IRQ: m_mode = CSM_MODE_FAST_IRQ;
			CSM_EV_IRQ: m_mode = CSM_MODE_IRQ;
			CSM_EV_SUPERVISOR_CALL: m_mode = CSM_MODE_SUPERVISOR;
			CSM_EV_DATA_ABORT, CSM_EV_PREFETCH_ABORT: m_mode = CSM_MODE_ABORT;
			CSM_EV_UNDEFINED: m_mode = CSM_MODE_UNDEFINED;
			default: ;
		endcase
		// A short fetch is illegal in the wide state, so both are faults.
		ff = m_iset ? fetch_addr_in[0] :
			(fetch_addr_in[1:0] != 2'h0) || !fetch_is_32_in;
		chk(mode_out, m_mode);
		chk(iset_out, m_iset);
		chk(protected_grant_out, protected_req_in && m_mode != CSM_MODE_USER);
		chk(privileged_out, m_mode != CSM_MODE_USER);
		chk(fetch_fault_out, ff);
		chk(phys_reg_out, (m_mode == CSM_MODE_FAST_IRQ && reg_index_in >= 8
			&& reg_index_in <= 14) ? reg_index_in + 8 : reg_index_in);
	endtask

	// Places the held access into lanes and compares the registered result.
	task automatic lanes_check;
		int off;
		int n;
		logic [31:0] d;
		logic [31:0] m;
		logic [3:0] en;
		off = access_in.addr[1:0];
		n = 1 << access_in.size;
		d = '0;
		m = '0;
		en = '0;
		for (int b = 0; b < n; b++)
			if (off + b < 4)
			begin
				en[off + b] = 1'b1;
				m[8 * (off + b) +: 8] = 8'hFF;
				d[8 * (off + b) +: 8] = access_in.wdata[8 *
					(access_in.big_endian ? n - 1 - b : b) +: 8];
			end
		chk(lanes_out.lane_en, en);
		chk(lanes_out.lane_data & m, d);
		chk(lanes_out.word_span, (off + n > 4) ? 2 : 1);
		chk(lanes_out.valid, access_in.valid);
		chk(lanes_out.allocate_l1, access_in.valid && region_cacheable_in
			&& !region_shared_in);
		chk(coherency_hw_out, 0);
	endtask

	// ****
	// Sequence
	// ****
	// Reset, random events of every kind, then back-to-back accesses.
	initial
	begin
		void'($urandom(32'h0000_D322));
		repeat (10) @(posedge sys_clk_in);
		#1;
		rst_in = 1'b0;
		chk(mode_out, CSM_RESET_MODE);
		chk(lanes_out.valid, 0);
		chk(iset_out, CSM_RESET_ISET);
		chk(privileged_out, 1);
		m_mode = csm_mode_t'(CSM_RESET_MODE);
		m_iset = CSM_RESET_ISET;
		for (int i = 0; i < 300; i++)
			ev(csm_event_t'($urandom_range(1, 12)), 1'($urandom), 1'($urandom),
				1'($urandom), $urandom_range(0, 1) ? CSM_MODE_USER :
				csm_mode_t'(5'($urandom)));
		for (int i = 0; i < 200; i++)
		begin
			access_in = {1'($urandom), $urandom, 2'($urandom_range(0, 2)),
				1'($urandom), $urandom};
			region_shared_in = 1'($urandom);
			region_cacheable_in = 1'($urandom);
			@(posedge sys_clk_in);
			#1;
			lanes_check;
		end
		stop_test;
	end

	// Cuts a hang short well after the expected run of about 810 cycles.
	initial
	begin
		#(2000 * 100);
		n_mismatch++;
		stop_test;
	end
endmodule
